// ---- rtl/pwm_status_pkg.sv ----
/*
 * Shared constants and carriers for the PWM timer flag, status and counter block.
 * Assumes a byte-addressed Avalon-MM master with 32-bit data.
 */
package pwm_status_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] EN_CLR_OFS   = 8'h24;
  localparam logic [7:0] EN_SET_OFS   = 8'h28;
  localparam logic [7:0] FLAGS_OFS    = 8'h2C;
  localparam logic [7:0] STATE_OFS    = 8'h30;
  localparam logic [7:0] COUNT_OFS    = 8'h34;
  localparam logic [7:0] CHAN_REG_OFS = 8'h44;
  localparam logic [7:0] PATT_BUF_OFS = 8'h64;
  localparam logic [7:0] WAVE_BUF_OFS = 8'h68;
  localparam logic [7:0] PER_BUF_OFS  = 8'h6C;
  localparam logic [7:0] CHAN_BUF_OFS = 8'h70;
  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int          FL_WRAP      = 0;
  localparam int          FL_RETRIG    = 1;
  localparam int          FL_CNT       = 2;
  localparam int          FL_ERR       = 3;
  localparam int          FL_UFS       = 10;
  localparam int          FL_DFS       = 11;
  localparam int          FL_SOFT      = 12;
  localparam int          FL_HARD      = 14;
  localparam int          FL_MC        = 16;
  localparam logic [23:0] FLAG_MASK    = 24'h0FFC0F;
  localparam logic [23:0] FLAG_RESET   = 24'h000000;
  localparam int          ST_STOP      = 0;
  localparam int          ST_IDX       = 1;
  localparam int          ST_UFS       = 2;
  localparam int          ST_DFS       = 3;
  localparam int          ST_SLAVE     = 4;
  localparam int          ST_PATTERN_BUFFER_VALID    = 5;
  localparam int          ST_WAVEFORM_BUFFER_VALID    = 6;
  localparam int          ST_PERIOD_BUFFER_VALID     = 7;
  localparam int          ST_LIVE      = 8;
  localparam int          ST_SOFT      = 12;
  localparam int          ST_HARD      = 14;
  localparam int          ST_CCBV      = 16;
  localparam int          ST_CMP       = 24;
  localparam logic        STOP_RESET   = 1'b1;
  localparam int          CNT_W        = 24;
  localparam int          FOUR_BIT_DITHERING_SHIFT  = 4;
  localparam logic [23:0] CNT_MASK     = 24'hFFFFFF;
  localparam logic [23:0] CNT_MASK_D4  = 24'h0FFFFF;
  localparam logic [1:0]  RAMP_SINGLE  = 2'h0;
  localparam logic [13:0] CTRL_MASK    = 14'h3FFF;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } avalon_req_t;

  typedef struct packed {
    logic [3:0] capture_mode;
    logic [1:0] soft_halt_sw;
    logic       four_bit_dithering;
    logic [1:0] ramp_mode;
    logic       single_run_mode;
    logic       fault_on_debug_enable;
    logic       master_sync_config;
    logic       lock_update_control;
    logic       spare;
  } ctrl_t;

  typedef struct packed {
    logic                   counter_event;
    logic                   retrigger;
    logic                   wrap;
    logic                   update;
    logic                   stop_cmd;
    logic                   count_inc;
    logic                   count_dec;
    logic                   ramp_cycle_b;
    logic                   debug_mode;
    logic [1:0]             fault_resume;
    logic [3:0]             match;
    logic [3:0]             capture;
    logic [3:0][CNT_W-1:0]  capture_value;
    logic [3:0]             channel_output_level;
  } engine_events_t;
endpackage

// ---- rtl/pwm_status_regs.sv ----
/*
 * Flag, status and counter-value registers of a control PWM timer, as an
 * Avalon-MM slave with waitrequest. Assumes the timer engine runs on clk and
 * hands in one-cycle event pulses; fault pins are asynchronous.
 */
// Added by the designer: register access over Avalon-MM.
// Notes on behaviour
// - Recoverable fault A/B flags rise one cycle after the fault.
// - Debug fault flag rises one cycle after entering debug fault state.
// - Update fault flag rises when ramp index changes under lock update.
// - Error flag rises when a capture meets a still-set channel flag.
// - Counter event, retrigger and wrap flags rise one cycle after their event.
// - Channel flags rise after a compare match or a stored capture.
// - Reading a capture channel register clears its channel flag.
// - Hard fault 0/1 flags rise one cycle after the fault.
// - Writing one clears a flag; writing zero leaves it.
// - Soft fault states set on fault; clear on resume or write-one with input low.
// - Clearing a soft fault state with software halt releases the counter.
// - Status bits 11:8 show live fault inputs.
// - Period, waveform, pattern buffer-valid set on write; clear on update or write-one.
// - Slave bit copies the master-sync configuration.
// - Debug fault state set in debug with enable; halts; clears outside debug only.
// - Update fault state sets on locked ramp change, forces outputs until write-one.
// - Ramp index reads cycle A/B in dual ramps, zero in single ramp.
// - Stop bit resets to one, sets on stop or one-shot update, clears on step.
// - Status bits 27:24 show channel compare outputs.
// - Channel buffer-valid follows compare-buffer writes or capture storage rules.
// - Hard fault states clear only by write-one with input low; count resumes.
// - Counter sits at 23:0, or 23:4 with four-bit dithering.
// - Enable mask set and clear views; request needs flag and enable.
`timescale 1ns/1ps
module pwm_status_regs
  import pwm_status_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire pwm_status_pkg::avalon_req_t   bus_req,
  output logic [31:0]                        readdata,
  output logic                               waitrequest,
  input  wire pwm_status_pkg::engine_events_t ev,
  input  wire logic [3:0]                    fault_pins,
  output logic                               counter_halted,
  output logic                               fault_outputs_forced,
  output logic                               source_request,
  output logic [CNT_W-1:0]                   count_value
);
  import pwm_status_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [3:0]             sync_first;
    logic [3:0]             sync_live;
    logic [3:0]             live_prev;
    ctrl_t                  ctrl;
    logic [23:0]            enable;
    logic [23:0]            flags;
    logic [1:0]             soft_state;
    logic [1:0]             hard_state;
    logic                   debug_halt_fault;
    logic                   dfs_prev;
    logic                   locked_update_fault;
    logic                   idx;
    logic                   stop;
    logic [2:0]             bufv;
    logic [3:0]             ccbv;
    logic [3:0][CNT_W-1:0]  chan;
    logic [CNT_W-1:0]       count;
    logic [31:0]            readdata;
    logic                   waitrequest;
    logic                   halted;
    logic                   forced;
    logic                   request;
  } state_t;

  state_t s_reg;
  state_t s_next;

  function automatic logic [3:0] chan_sel(input logic [7:0] a, input logic [7:0] base);
    logic [3:0] hit;
    hit = 4'h0;
    for (int i = 0; i < 4; i++) begin
      hit[i] = (a == base + 8'(4 * i));
    end
    return hit;
  endfunction

  function automatic logic [CNT_W-1:0] cnt_mask(input logic dith);
    return dith ? CNT_MASK_D4 : CNT_MASK;
  endfunction

  // ************************************************************
  // Next-state logic
  // ************************************************************
  logic        acc;
  logic        wr;
  logic        rd;
  logic [31:0] w;
  logic [7:0]  a;
  logic [3:0]  live;
  logic [3:0]  rise;
  logic [3:0]  creg_hit;
  logic [3:0]  cbuf_hit;
  logic [23:0] fl_set;
  logic [23:0] fl_clr;
  logic [31:0] status;
  logic [31:0] rmux;
  logic        idx_eff;
  logic        ufs_ev;
  logic        step;
  logic [3:0]  stored;
  logic [3:0]  cv_set;
  logic [3:0]  cv_clr;

  always_comb begin
    s_next   = s_reg;
    a        = bus_req.address;
    w        = bus_req.writedata;
    acc      = ~s_reg.waitrequest & (bus_req.read | bus_req.write);
    wr       = acc & bus_req.write;
    rd       = acc & bus_req.read;
    creg_hit = chan_sel(a, CHAN_REG_OFS);
    cbuf_hit = chan_sel(a, CHAN_BUF_OFS);
    live     = s_reg.sync_live;
    rise     = s_reg.sync_live & ~s_reg.live_prev;
    // First stage feeds only the second stage
    s_next.sync_first = fault_pins;
    s_next.sync_live  = s_reg.sync_first;
    s_next.live_prev  = s_reg.sync_live;

    if (wr && a == CTRL_OFS) begin
      s_next.ctrl = ctrl_t'(w[13:0] & CTRL_MASK);
    end
    if (wr && a == EN_SET_OFS) begin
      s_next.enable = s_reg.enable | (w[23:0] & FLAG_MASK);
    end
    if (wr && a == EN_CLR_OFS) begin
      s_next.enable = s_reg.enable & ~(w[23:0] & FLAG_MASK);
    end

    idx_eff = (s_reg.ctrl.ramp_mode == RAMP_SINGLE) ? 1'b0 : ev.ramp_cycle_b;
    s_next.idx = idx_eff;
    ufs_ev = s_reg.ctrl.lock_update_control & (idx_eff != s_reg.idx);

    // A capture only lands while the channel flag is clear; otherwise it is lost
    stored = ev.capture & s_reg.ctrl.capture_mode & ~s_reg.flags[FL_MC +: 4];

    fl_set = 24'h0;
    fl_set[FL_WRAP]       = ev.wrap;
    fl_set[FL_RETRIG]     = ev.retrigger;
    fl_set[FL_CNT]        = ev.counter_event;
    fl_set[FL_ERR]        = |(ev.capture & s_reg.flags[FL_MC +: 4]);
    fl_set[FL_UFS]        = ufs_ev;
    fl_set[FL_DFS]        = s_reg.debug_halt_fault & ~s_reg.dfs_prev;
    fl_set[FL_SOFT +: 2]  = rise[1:0];
    fl_set[FL_HARD +: 2]  = rise[3:2];
    fl_set[FL_MC +: 4]    = ev.match | stored;
    fl_clr = (wr && a == FLAGS_OFS) ? (w[23:0] & FLAG_MASK) : 24'h0;
    fl_clr[FL_MC +: 4] = fl_clr[FL_MC +: 4] | ({4{rd}} & creg_hit & s_reg.ctrl.capture_mode);
    // Set wins over a clear in the same cycle
    s_next.flags = ((s_reg.flags & ~fl_clr) | fl_set) & FLAG_MASK;

    for (int i = 0; i < 2; i++) begin
      if (rise[i]) begin
        s_next.soft_state[i] = 1'b1;
      end else if (ev.fault_resume[i] || (wr && a == STATE_OFS && w[ST_SOFT + i] && !live[i])) begin
        s_next.soft_state[i] = 1'b0;
      end
      if (rise[2 + i]) begin
        s_next.hard_state[i] = 1'b1;
      end else if (wr && a == STATE_OFS && w[ST_HARD + i] && !live[2 + i]) begin
        s_next.hard_state[i] = 1'b0;
      end
    end

    s_next.dfs_prev = s_reg.debug_halt_fault;
    if (ev.debug_mode && s_reg.ctrl.fault_on_debug_enable) begin
      s_next.debug_halt_fault = 1'b1;
    end else if (wr && a == STATE_OFS && w[ST_DFS] && !ev.debug_mode) begin
      s_next.debug_halt_fault = 1'b0;
    end
    if (ufs_ev) begin
      s_next.locked_update_fault = 1'b1;
    end else if (wr && a == STATE_OFS && w[ST_UFS]) begin
      s_next.locked_update_fault = 1'b0;
    end

    for (int i = 0; i < 3; i++) begin
      if (wr && a == (i == 0 ? PATT_BUF_OFS : i == 1 ? WAVE_BUF_OFS : PER_BUF_OFS)) begin
        s_next.bufv[i] = 1'b1;
      end else if (ev.update || (wr && a == STATE_OFS && w[ST_PATTERN_BUFFER_VALID + i])) begin
        s_next.bufv[i] = 1'b0;
      end
    end

    cv_set = ({4{wr}} & cbuf_hit & ~s_reg.ctrl.capture_mode) | stored;
    cv_clr = ({4{wr && a == STATE_OFS}} & w[ST_CCBV +: 4])
           | ({4{ev.update}} & ~s_reg.ctrl.capture_mode)
           | ({4{rd}} & creg_hit & s_reg.ctrl.capture_mode);
    s_next.ccbv = (s_reg.ccbv & ~cv_clr) | cv_set;
    for (int i = 0; i < 4; i++) begin
      if (stored[i]) begin
        s_next.chan[i] = ev.capture_value[i];
      end else if (wr && creg_hit[i]) begin
        s_next.chan[i] = w[CNT_W-1:0];
      end
    end

    // Halt sources hold the count; a released soft fault lets it run again
    step = ~s_reg.halted & (ev.count_inc ^ ev.count_dec);
    if (wr && a == COUNT_OFS) begin
      s_next.count = s_reg.ctrl.four_bit_dithering ? (w[CNT_W-1:0] >> FOUR_BIT_DITHERING_SHIFT)
                                                   : w[CNT_W-1:0];
    end else if (step) begin
      s_next.count = (ev.count_inc ? s_reg.count + 24'h000001 : s_reg.count - 24'h000001)
                     & cnt_mask(s_reg.ctrl.four_bit_dithering);
    end
    if (ev.stop_cmd || (ev.update && s_reg.ctrl.single_run_mode)) begin
      s_next.stop = 1'b1;
    end else if (step) begin
      s_next.stop = 1'b0;
    end

    status = 32'h0;
    status[ST_STOP]      = s_reg.stop;
    status[ST_IDX]       = s_reg.idx;
    status[ST_UFS]       = s_reg.locked_update_fault;
    status[ST_DFS]       = s_reg.debug_halt_fault;
    status[ST_SLAVE]     = s_reg.ctrl.master_sync_config;
    status[ST_PATTERN_BUFFER_VALID +: 3] = s_reg.bufv;
    status[ST_LIVE +: 4] = live;
    status[ST_SOFT +: 2] = s_reg.soft_state;
    status[ST_HARD +: 2] = s_reg.hard_state;
    status[ST_CCBV +: 4] = s_reg.ccbv;
    status[ST_CMP +: 4]  = ev.channel_output_level;

    rmux = 32'h0;
    if (a == CTRL_OFS) begin
      rmux[13:0] = s_reg.ctrl;
    end else if (a == EN_SET_OFS || a == EN_CLR_OFS) begin
      rmux[23:0] = s_reg.enable;
    end else if (a == FLAGS_OFS) begin
      rmux[23:0] = s_reg.flags;
    end else if (a == STATE_OFS) begin
      rmux = status;
    end else if (a == COUNT_OFS) begin
      rmux[23:0] = s_reg.ctrl.four_bit_dithering ? (s_reg.count << FOUR_BIT_DITHERING_SHIFT)
                                                 : s_reg.count;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (creg_hit[i]) begin
          rmux[CNT_W-1:0] = s_reg.chan[i];
        end
      end
    end

    // One wait cycle, then the access completes
    s_next.waitrequest = ~(s_reg.waitrequest & (bus_req.read | bus_req.write));
    if (s_reg.waitrequest && bus_req.read) begin
      s_next.readdata = rmux;
    end
    s_next.halted  = s_next.debug_halt_fault | (|(s_next.soft_state & s_next.ctrl.soft_halt_sw))
                   | (|s_next.hard_state);
    s_next.forced  = s_next.debug_halt_fault | s_next.locked_update_fault | (|s_next.hard_state);
    s_next.request = |(s_next.flags & s_next.enable);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg             <= '0;
      s_reg.flags       <= FLAG_RESET;
      s_reg.stop        <= STOP_RESET;
      s_reg.waitrequest <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign readdata             = s_reg.readdata;
  assign waitrequest          = s_reg.waitrequest;
  assign counter_halted       = s_reg.halted;
  assign fault_outputs_forced = s_reg.forced;
  assign source_request       = s_reg.request;
  assign count_value          = s_reg.count;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wrap_flag_a: assert property (ev.wrap |=> s_reg.flags[FL_WRAP])
    else $error("wrap flag not raised");
  flag_clear_a: assert property (
    wr && a == FLAGS_OFS && w[FL_CNT] && !ev.counter_event |=> !s_reg.flags[FL_CNT])
    else $error("counter flag not cleared by write one");
  // A software write to the same channel register may legally change the value
  overrun_flag_a: assert property (
    ev.capture[0] && s_reg.flags[FL_MC] && !(wr && creg_hit[0])
    |=> s_reg.flags[FL_ERR] && $stable(s_reg.chan[0]))
    else $error("capture overrun not flagged");
  capture_read_a: assert property (
    rd && creg_hit[0] && s_reg.ctrl.capture_mode[0] && !ev.match[0] && !ev.capture[0]
    |=> !s_reg.flags[FL_MC] && !s_reg.ccbv[0])
    else $error("capture read did not clear channel flag");
  soft_fault_a: assert property (
    $rose(s_reg.sync_live[0]) |=> s_reg.flags[FL_SOFT] && s_reg.soft_state[0])
    else $error("soft fault A not flagged");
  // Halt follows the state at the same edge; a later write-one may already clear it
  hard_fault_a: assert property (
    $rose(s_reg.sync_live[3]) |=> s_reg.flags[FL_HARD + 1] && s_reg.halted)
    else $error("hard fault 1 not flagged");
  debug_flag_a: assert property ($rose(s_reg.debug_halt_fault) |=> s_reg.flags[FL_DFS])
    else $error("debug fault flag late");
  locked_update_a: assert property (
    ufs_ev |=> s_reg.locked_update_fault && s_reg.flags[FL_UFS] && s_reg.forced)
    else $error("locked update fault missed");
  stop_bit_a: assert property (ev.stop_cmd |=> s_reg.stop)
    else $error("stop bit not set");
  stop_clear_a: assert property (
    ev.count_inc && !ev.count_dec && !s_reg.halted && !ev.stop_cmd && !ev.update
    |=> !s_reg.stop)
    else $error("stop bit not cleared by a step");
  debug_halt_a: assert property (
    ev.debug_mode && s_reg.ctrl.fault_on_debug_enable |=> s_reg.debug_halt_fault && s_reg.halted)
    else $error("debug fault state did not halt");
  // Only a bus write may move the count while a halt source is active
  count_hold_a: assert property (
    s_reg.halted && !(wr && a == COUNT_OFS) |=> $stable(s_reg.count))
    else $error("count moved while halted");
  buffer_valid_a: assert property (
    wr && a == PER_BUF_OFS |=> s_reg.bufv[2])
    else $error("period buffer valid not set");
  bus_answer_a: assert property ((bus_req.read || bus_req.write) && waitrequest
    |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest sequence wrong");

  read_done_c: cover property (rd ##1 !bus_req.read);
  overrun_c: cover property (ev.capture[0] && s_reg.flags[FL_MC]);
  debug_entry_c: cover property ($rose(s_reg.debug_halt_fault));
  hard_fault_c: cover property ($rose(s_reg.hard_state[1]));
  request_c: cover property ($rose(source_request));
endmodule

// ---- testbench/pwm_status_regs_test.sv ----
/*
 * Self-checking bench for the PWM flag, status and counter registers.
 * Assumes pwm_status_pkg is compiled first; the bench drives the bus,
 * engine events and fault pins itself; assertions live in the design.
 */
`timescale 1ns/1ps
module pwm_status_regs_test;
  import pwm_status_pkg::*;
  logic           clk;
  logic           reset;
  avalon_req_t    bus_req;
  logic [31:0]    readdata;
  logic           waitrequest;
  engine_events_t ev;
  engine_events_t p;
  logic [3:0]     fault_pins;
  logic           counter_halted;
  logic           fault_outputs_forced;
  logic           source_request;
  logic [CNT_W-1:0] count_value;
  logic [31:0]    rd;
  int             miscompares;
  int             num_checks;

  pwm_status_regs pwm_status_regs_i (
    .clk                  (clk),
    .reset                (reset),
    .bus_req              (bus_req),
    .readdata             (readdata),
    .waitrequest          (waitrequest),
    .ev                   (ev),
    .fault_pins           (fault_pins),
    .counter_halted       (counter_halted),
    .fault_outputs_forced (fault_outputs_forced),
    .source_request       (source_request),
    .count_value          (count_value)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ************************************************************
  // Bus and check helpers
  // ************************************************************
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until waitrequest is sampled low; bound cuts a hang
  task access(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    bus_req <= '{a, ~wr, wr, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      miscompares++;
      complete_run;
    end else begin
      rd = readdata;
      bus_req <= '0;
    end
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    access(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd & m, e);
  endtask

  // One-cycle pulse on the fields set in p
  task pulse;
    @(posedge clk);
    ev <= engine_events_t'(ev | p);
    @(posedge clk);
    ev <= engine_events_t'(ev & ~p);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    bus_req = '0;
    ev = '0;
    p = '0;
    fault_pins = '0;
    miscompares = 0;
    num_checks = 0;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rchk(FLAGS_OFS, 32'hFFFFFFFF, 32'h0);
    rchk(STATE_OFS, 32'hFFFFFFFF, 32'h1);
    rchk(COUNT_OFS, 32'hFFFFFFFF, 32'h0);
    rchk(8'hFC, 32'hFFFFFFFF, 32'h0);
    p.wrap = 1'b1;
    p.retrigger = 1'b1;
    p.counter_event = 1'b1;
    pulse;
    rchk(FLAGS_OFS, 32'hFFFFFFFF, 32'h7);
    access(1'b1, FLAGS_OFS, 32'h0);
    rchk(FLAGS_OFS, 32'hFFFFFFFF, 32'h7);
    access(1'b1, FLAGS_OFS, 32'h2);
    rchk(FLAGS_OFS, 32'hFFFFFFFF, 32'h5);
    access(1'b1, EN_SET_OFS, 32'h1);
    rchk(EN_CLR_OFS, 32'hFFFFFFFF, 32'h1);
    check("request", {31'h0, source_request}, 32'h1);
    access(1'b1, EN_CLR_OFS, 32'h1);
    repeat (2) @(posedge clk);
    check("request", {31'h0, source_request}, 32'h0);
    access(1'b1, FLAGS_OFS, 32'hFFFFFF);
    p = '0;
    p.match = 4'h4;
    pulse;
    rchk(FLAGS_OFS, 32'hFFFFFFFF, 32'h40000);
    // Capture on channel 0, then a second one that must be refused
    access(1'b1, CTRL_OFS, 32'h400);
    p = '0;
    p.capture = 4'h1;
    p.capture_value[0] = 24'h123456;
    pulse;
    p.capture_value[0] = 24'h654321;
    pulse;
    rchk(FLAGS_OFS, 32'hF000F, 32'h50008);
    rchk(STATE_OFS, 32'hF0000, 32'h10000);
    rchk(CHAN_REG_OFS, 32'hFFFFFFFF, 32'h123456);
    rchk(FLAGS_OFS, 32'hF000F, 32'h40008);
    rchk(STATE_OFS, 32'hF0000, 32'h0);
    access(1'b1, FLAGS_OFS, 32'hFFFFFF);
    for (int i = 0; i < 4; i++) begin
      fault_pins <= 4'h1 << i;
      repeat (4) @(posedge clk);
      rchk(STATE_OFS, 32'hFF00, 32'h1100 << i);
      rchk(FLAGS_OFS, 32'hFFFFFF, 32'h1000 << i);
      check("halted", {31'h0, counter_halted}, 32'(i > 1));
      access(1'b1, STATE_OFS, 32'h1000 << i);
      rchk(STATE_OFS, 32'hF000, 32'h1000 << i);
      fault_pins <= '0;
      repeat (4) @(posedge clk);
      access(1'b1, STATE_OFS, 32'h1000 << i);
      rchk(STATE_OFS, 32'hFF00, 32'h0);
      access(1'b1, FLAGS_OFS, 32'h1000 << i);
    end
    // Software-halt soft fault: clear by resume, then by write-one
    access(1'b1, CTRL_OFS, 32'h100);
    fault_pins <= 4'h1;
    repeat (4) @(posedge clk);
    check("halted", {31'h0, counter_halted}, 32'h1);
    fault_pins <= '0;
    p = '0;
    p.fault_resume = 2'h1;
    pulse;
    rchk(STATE_OFS, 32'h1000, 32'h0);
    check("halted", {31'h0, counter_halted}, 32'h0);
    fault_pins <= 4'h1;
    repeat (4) @(posedge clk);
    fault_pins <= '0;
    repeat (4) @(posedge clk);
    check("halted", {31'h0, counter_halted}, 32'h1);
    access(1'b1, STATE_OFS, 32'h1000);
    @(posedge clk);
    check("halted", {31'h0, counter_halted}, 32'h0);
    access(1'b1, CTRL_OFS, 32'h8);
    ev.debug_mode <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(STATE_OFS, 32'h8, 32'h8);
    rchk(FLAGS_OFS, 32'h800, 32'h800);
    check("halted", {31'h0, counter_halted}, 32'h1);
    access(1'b1, STATE_OFS, 32'h8);
    rchk(STATE_OFS, 32'h8, 32'h8);
    ev.debug_mode <= 1'b0;
    access(1'b1, STATE_OFS, 32'h8);
    rchk(STATE_OFS, 32'h8, 32'h0);
    access(1'b1, CTRL_OFS, 32'h24);
    rchk(STATE_OFS, 32'h16, 32'h10);
    ev.ramp_cycle_b <= 1'b1;
    rchk(STATE_OFS, 32'h16, 32'h12);
    access(1'b1, CTRL_OFS, 32'h22);
    ev.ramp_cycle_b <= 1'b0;
    rchk(FLAGS_OFS, 32'h400, 32'h400);
    rchk(STATE_OFS, 32'h16, 32'h4);
    check("forced", {31'h0, fault_outputs_forced}, 32'h1);
    access(1'b1, STATE_OFS, 32'h4);
    rchk(STATE_OFS, 32'h4, 32'h0);
    access(1'b1, CTRL_OFS, 32'h0);
    ev.ramp_cycle_b <= 1'b1;
    rchk(STATE_OFS, 32'h16, 32'h0);
    access(1'b1, PER_BUF_OFS, 32'h1);
    access(1'b1, WAVE_BUF_OFS, 32'h1);
    access(1'b1, PATT_BUF_OFS, 32'h1);
    access(1'b1, CHAN_BUF_OFS + 8'h04, 32'h1);
    rchk(STATE_OFS, 32'hF00E0, 32'h200E0);
    access(1'b1, STATE_OFS, 32'h20080);
    rchk(STATE_OFS, 32'hF00E0, 32'h60);
    access(1'b1, CHAN_BUF_OFS, 32'h1);
    p = '0;
    p.update = 1'b1;
    pulse;
    rchk(STATE_OFS, 32'hF00E0, 32'h0);
    ev.channel_output_level <= 4'hA;
    rchk(STATE_OFS, 32'hFF000000, 32'h0A000000);
    access(1'b1, COUNT_OFS, 32'hFFABCDEF);
    rchk(COUNT_OFS, 32'hFFFFFFFF, 32'h00ABCDEF);
    p = '0;
    p.count_inc = 1'b1;
    pulse;
    rchk(STATE_OFS, 32'h1, 32'h0);
    rchk(COUNT_OFS, 32'hFFFFFFFF, 32'h00ABCDF0);
    p = '0;
    p.stop_cmd = 1'b1;
    pulse;
    rchk(STATE_OFS, 32'h1, 32'h1);
    access(1'b1, CTRL_OFS, 32'h10);
    p = '0;
    p.count_dec = 1'b1;
    pulse;
    rchk(STATE_OFS, 32'h1, 32'h0);
    p = '0;
    p.update = 1'b1;
    pulse;
    rchk(STATE_OFS, 32'h1, 32'h1);
    access(1'b1, CTRL_OFS, 32'h80);
    access(1'b1, COUNT_OFS, 32'hFFFFFFFF);
    rchk(COUNT_OFS, 32'hFFFFFFFF, 32'h00FFFFF0);
    check("count", {8'h0, count_value}, 32'h000FFFFF);
    complete_run;
  end
endmodule
